// file: shared/sbhsc_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial host.
`ifndef SBHSC_REGS_SVH
`define SBHSC_REGS_SVH
`define SBHSC_OFF_DATA 8'hb0
`define SBHSC_OFF_INDEX 8'hb1
`define SBHSC_OFF_TARGET 8'hb2
`define SBHSC_OFF_CTRL 8'hb3
`define SBHSC_BIT_SHORT 7
`define SBHSC_BIT_RSVD 6
`define SBHSC_BIT_REQBSY 5
`define SBHSC_BIT_LOADBSY 4
`define SBHSC_BIT_PRESENT 3
`define SBHSC_BIT_FAST 2
`define SBHSC_BIT_REQERR 1
`define SBHSC_BIT_LOADERR 0
`define SBHSC_RESET_BYTE 8'h00
`define SBHSC_CLK_HZ 50000000
`define SBHSC_SCL_HZ 100000
`define SBHSC_FAST_SCL_HZ 400000
`define SBHSC_QUARTER_NORMAL (`SBHSC_CLK_HZ / (4 * `SBHSC_SCL_HZ))
`define SBHSC_QUARTER_FAST (`SBHSC_CLK_HZ / (4 * `SBHSC_FAST_SCL_HZ))
`define SBHSC_LOAD_BYTES 4
`define SBHSC_LOAD_TAG 8'ha5
`endif

// file: shared/sbhsc_pkg.sv
// Types shared by the serial host files.
package sbhsc_pkg;
	// Byte engine states.
	typedef enum logic [3:0] {
		SBHSC_IDLE, SBHSC_START, SBHSC_BIT, SBHSC_ACK, SBHSC_RSTART, SBHSC_STOP
	} sbhsc_state_t;
	// Phases of one transaction.
	typedef enum logic [2:0] {
		SBHSC_PH_ADDR, SBHSC_PH_INDEX, SBHSC_PH_RADDR, SBHSC_PH_DATA, SBHSC_PH_DONE
	} sbhsc_phase_t;
endpackage

// file: src/sbhsc_tick.sv
// Clock divider producing a quarter-bit enable pulse for the serial bus.
`timescale 1ns/1ns
`include "sbhsc_regs.svh"
module sbhsc_tick #(
	parameter int NORMAL = `SBHSC_QUARTER_NORMAL,
	parameter int FAST = `SBHSC_QUARTER_FAST
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fast,
	output logic tick
);
	// Down counter width covers the slow rate.
	localparam int W = $clog2(NORMAL + 1);
	logic [W-1:0] cnt_q;
	// Reload value follows the test-clock selection.
	wire [W-1:0] reload = fast ? W'(FAST - 1) : W'(NORMAL - 1);
	wire at_zero = (cnt_q == '0);
	// Counts down and pulses once per quarter bit.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else begin
			cnt_q <= at_zero ? reload : cnt_q - 1'b1;
			tick <= at_zero;
		end
	end
endmodule

// file: src/sbhsc_top.sv
// Serial bus host control and status logic with byte engine and auto-load.
`timescale 1ns/1ns
`include "sbhsc_regs.svh"
module sbhsc_top #(
	parameter int LOAD_BYTES = `SBHSC_LOAD_BYTES,
	parameter logic [6:0] ROM_ADDR = 7'h50
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	input wire logic latch_pin,
	output logic pins_free,
	output logic [7:0] subsys_byte,
	output logic [1:0] subsys_idx,
	output logic subsys_valid
);
	// Two-stage synchronisers for pins.
	logic [1:0] sda_s_q, scl_s_q, latch_s_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sda_s_q <= 2'b11;
			scl_s_q <= 2'b11;
			latch_s_q <= 2'b11;
		end else begin
			sda_s_q <= {sda_s_q[0], sda_in};
			scl_s_q <= {scl_s_q[0], scl_in};
			latch_s_q <= {latch_s_q[0], latch_pin};
		end
	end
	wire sda_sync = sda_s_q[1];
	wire latch_sync = latch_s_q[1];

	// Software-visible registers.
	logic [7:0] data_q, index_q, target_q;
	logic short_q, fast_q, req_busy_q, load_busy_q, present_q, req_err_q, load_err_q;
	logic strap_done_q;
	logic [1:0] strap_wait_q; // Edges since release; the strap must first pass the synchroniser.
	// Engine state.
	sbhsc_pkg::sbhsc_state_t st_q;
	sbhsc_pkg::sbhsc_phase_t ph_q;
	logic [1:0] qtr_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic nack_q, autoload_q, fmt_bad_q;
	logic [2:0] load_cnt_q;
	logic tick;

	// Quarter-bit enable at the normal or test rate.
	// selectable clock rate
	sbhsc_tick u_tick (
		.clk(clk),
		.rst_b(rst_b),
		.fast(fast_q),
		.tick(tick)
	);

	// Bus-side decode.
	wire wr_data = cfg_wr && (cfg_addr == `SBHSC_OFF_DATA);
	wire wr_index = cfg_wr && (cfg_addr == `SBHSC_OFF_INDEX);
	wire wr_target = cfg_wr && (cfg_addr == `SBHSC_OFF_TARGET);
	wire wr_ctrl = cfg_wr && (cfg_addr == `SBHSC_OFF_CTRL);
	wire launch = wr_target && !req_busy_q && !load_busy_q && present_q;
	wire [7:0] ctrl_view = {short_q, 1'b0, req_busy_q, load_busy_q, present_q, fast_q, req_err_q, load_err_q};
	wire [7:0] rdata_d = (cfg_addr == `SBHSC_OFF_DATA) ? data_q :
		(cfg_addr == `SBHSC_OFF_INDEX) ? index_q :
		(cfg_addr == `SBHSC_OFF_TARGET) ? target_q :
		(cfg_addr == `SBHSC_OFF_CTRL) ? ctrl_view : 8'h00;

	// Read data is registered.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) cfg_rdata <= `SBHSC_RESET_BYTE;
		else cfg_rdata <= rdata_d;
	end

	// Sample strobes, end-of-transaction event and phase decodes from the engine.
	wire done_ev = tick && (st_q == sbhsc_pkg::SBHSC_STOP) && (qtr_q == 2'd3);
	wire ack_sample = tick && (st_q == sbhsc_pkg::SBHSC_ACK) && (qtr_q == 2'd2);
	wire byte_sample = tick && (st_q == sbhsc_pkg::SBHSC_BIT) && (qtr_q == 2'd2);
	wire reading = target_q[0] && !autoload_q;
	wire rx_phase = (ph_q == sbhsc_pkg::SBHSC_PH_DATA) && (autoload_q || target_q[0]);
	wire last_load = (load_cnt_q == 3'(LOAD_BYTES - 1));
	// The strap is taken on the third edge after release, once the synchroniser has flushed its reset value.
	wire strap_take = (strap_wait_q == 2'd2) && !strap_done_q;

	// Presence strap caught once after reset release; pulldown means present.
	// detect interface
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_wait_q <= 2'd0;
			strap_done_q <= 1'b0;
			present_q <= 1'b0;
		end else begin
			if (strap_wait_q != 2'd2) strap_wait_q <= strap_wait_q + 2'd1;
			if (strap_take) begin
				strap_done_q <= 1'b1;
				present_q <= !latch_sync;
			end else if (wr_ctrl && cfg_wdata[`SBHSC_BIT_PRESENT]) begin
				present_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) pins_free <= 1'b1;
		else pins_free <= !present_q;
	end

	// Control bits written by software.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			short_q <= 1'b0;
			fast_q <= 1'b0;
		end else if (wr_ctrl) begin
			short_q <= cfg_wdata[`SBHSC_BIT_SHORT];
			fast_q <= cfg_wdata[`SBHSC_BIT_FAST];
		end
	end

	// Index and target registers; target write starts a request.
	// address and direction
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			index_q <= `SBHSC_RESET_BYTE;
			target_q <= `SBHSC_RESET_BYTE;
		end else begin
			if (wr_index) index_q <= cfg_wdata;
			if (launch) target_q <= cfg_wdata;
		end
	end

	// Data register: software write or received byte.
	// store read byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) data_q <= `SBHSC_RESET_BYTE;
		else if (ack_sample && reading && rx_phase) data_q <= sh_q;
		else if (wr_data && !req_busy_q) data_q <= cfg_wdata;
	end

	// Busy flags.
	// set busy
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_busy_q <= 1'b0;
			load_busy_q <= 1'b0;
		end else begin
			if (launch) req_busy_q <= 1'b1;
			else if (done_ev && !autoload_q) req_busy_q <= 1'b0;
			if (strap_take) load_busy_q <= !latch_sync;
			else if (done_ev && autoload_q && (last_load || nack_q || fmt_bad_q)) load_busy_q <= 1'b0;
		end
	end

	// Error flags: set wins over write-one clear.
	wire err_set = done_ev && nack_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			req_err_q <= 1'b0;
			load_err_q <= 1'b0;
		end else begin
			if (err_set && !autoload_q) req_err_q <= 1'b1;
			else if (wr_ctrl && cfg_wdata[`SBHSC_BIT_REQERR]) req_err_q <= 1'b0;
			if (done_ev && autoload_q && (nack_q || fmt_bad_q)) load_err_q <= 1'b1;
			else if (wr_ctrl && cfg_wdata[`SBHSC_BIT_LOADERR]) load_err_q <= 1'b0;
		end
	end

	// Next phase after an acknowledged byte.
	// short protocol
	wire use_short = short_q && !autoload_q;
	wire is_read = autoload_q || target_q[0];
	sbhsc_pkg::sbhsc_phase_t ph_next;
	always_comb begin
		ph_next = sbhsc_pkg::SBHSC_PH_DONE;
		case (ph_q)
			sbhsc_pkg::SBHSC_PH_ADDR: ph_next = use_short ? sbhsc_pkg::SBHSC_PH_DATA : sbhsc_pkg::SBHSC_PH_INDEX;
			sbhsc_pkg::SBHSC_PH_INDEX: ph_next = is_read ? sbhsc_pkg::SBHSC_PH_RADDR : sbhsc_pkg::SBHSC_PH_DATA;
			sbhsc_pkg::SBHSC_PH_RADDR: ph_next = sbhsc_pkg::SBHSC_PH_DATA;
			default: ph_next = sbhsc_pkg::SBHSC_PH_DONE;
		endcase
	end
	// First transmitted byte: address with direction, or write address before a combined read.
	wire [7:0] first_byte = autoload_q ? {ROM_ADDR, 1'b0} : (use_short ? target_q : {target_q[7:1], 1'b0});
	wire [7:0] raddr_byte = autoload_q ? {ROM_ADDR, 1'b1} : {target_q[7:1], 1'b1};
	wire [7:0] next_tx = (ph_next == sbhsc_pkg::SBHSC_PH_INDEX) ? index_q :
		(ph_next == sbhsc_pkg::SBHSC_PH_DATA) ? data_q : 8'h00;
	wire [7:0] idx_byte = autoload_q ? {5'h00, load_cnt_q} : index_q;

	// Byte engine, one step per quarter-bit tick.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= sbhsc_pkg::SBHSC_IDLE;
			ph_q <= sbhsc_pkg::SBHSC_PH_ADDR;
			qtr_q <= 2'd0;
			bit_q <= 3'd7;
			sh_q <= 8'h00;
			nack_q <= 1'b0;
			autoload_q <= 1'b0;
			fmt_bad_q <= 1'b0;
			load_cnt_q <= 3'd0;
			scl_out <= 1'b1;
			sda_out <= 1'b1;
		end else if (st_q == sbhsc_pkg::SBHSC_IDLE) begin
			qtr_q <= 2'd0;
			if (launch || (load_busy_q && strap_done_q && !done_ev)) begin
				autoload_q <= !launch;
				nack_q <= 1'b0;
				ph_q <= sbhsc_pkg::SBHSC_PH_ADDR;
				sh_q <= launch ? ((short_q ? cfg_wdata : {cfg_wdata[7:1], 1'b0})) : {ROM_ADDR, 1'b0};
				st_q <= sbhsc_pkg::SBHSC_START;
			end
		end else if (tick) begin
			qtr_q <= qtr_q + 2'd1;
			case (st_q)
				sbhsc_pkg::SBHSC_START, sbhsc_pkg::SBHSC_RSTART: begin
					// Data falls while the clock is high.
					if (qtr_q == 2'd0) begin scl_out <= 1'b1; sda_out <= 1'b1; end
					if (qtr_q == 2'd1) sda_out <= 1'b0;
					if (qtr_q == 2'd3) begin scl_out <= 1'b0; bit_q <= 3'd7; st_q <= sbhsc_pkg::SBHSC_BIT; end
				end
				sbhsc_pkg::SBHSC_BIT: begin
					if (qtr_q == 2'd0) sda_out <= rx_phase ? 1'b1 : sh_q[bit_q];
					if (qtr_q == 2'd1) scl_out <= 1'b1;
					if (qtr_q == 2'd2 && rx_phase) sh_q[bit_q] <= sda_sync;
					if (qtr_q == 2'd3) begin
						scl_out <= 1'b0;
						bit_q <= bit_q - 3'd1;
						if (bit_q == 3'd0) st_q <= sbhsc_pkg::SBHSC_ACK;
					end
				end
				sbhsc_pkg::SBHSC_ACK: begin
					// Host never acknowledges a read byte; slave must acknowledge others.
					if (qtr_q == 2'd0) sda_out <= 1'b1;
					if (qtr_q == 2'd1) scl_out <= 1'b1;
					if (qtr_q == 2'd2 && !rx_phase && sda_sync) nack_q <= 1'b1;
					if (qtr_q == 2'd2 && rx_phase && autoload_q && load_cnt_q == 3'd0 && sh_q != `SBHSC_LOAD_TAG)
						fmt_bad_q <= 1'b1;
					if (qtr_q == 2'd3) begin
						scl_out <= 1'b0;
						if (nack_q || ph_next == sbhsc_pkg::SBHSC_PH_DONE) st_q <= sbhsc_pkg::SBHSC_STOP;
						else if (ph_next == sbhsc_pkg::SBHSC_PH_RADDR) begin
							st_q <= sbhsc_pkg::SBHSC_RSTART;
							sh_q <= raddr_byte;
						end else begin
							st_q <= sbhsc_pkg::SBHSC_BIT;
							sh_q <= (ph_next == sbhsc_pkg::SBHSC_PH_INDEX) ? idx_byte : next_tx;
						end
						bit_q <= 3'd7;
						ph_q <= ph_next;
					end
				end
				sbhsc_pkg::SBHSC_STOP: begin
					// Data rises while the clock is high.
					if (qtr_q == 2'd0) sda_out <= 1'b0;
					if (qtr_q == 2'd1) scl_out <= 1'b1;
					if (qtr_q == 2'd2) sda_out <= 1'b1;
					if (qtr_q == 2'd3) begin
						st_q <= sbhsc_pkg::SBHSC_IDLE;
						if (autoload_q) load_cnt_q <= load_cnt_q + 3'd1;
						if (autoload_q && (nack_q || fmt_bad_q)) fmt_bad_q <= 1'b0;
					end
				end
				default: st_q <= sbhsc_pkg::SBHSC_IDLE;
			endcase
		end
	end

	// Open-drain drive: enable pulls low only while present.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= present_q && !scl_out;
			sda_oe <= present_q && !sda_out;
		end
	end

	// Auto-loaded bytes delivered to the identifier registers elsewhere.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			subsys_byte <= 8'h00;
			subsys_idx <= 2'd0;
			subsys_valid <= 1'b0;
		end else begin
			subsys_valid <= ack_sample && autoload_q && rx_phase;
			if (ack_sample && autoload_q && rx_phase) begin
				subsys_byte <= sh_q;
				subsys_idx <= load_cnt_q[1:0];
			end
		end
	end
endmodule

// file: testbench/sbhsc_properties.sv
// Port checker of the serial host.
`timescale 1ns/1ns
module sbhsc_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	input wire logic [7:0] cfg_rdata,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic pins_free
);
	logic fast_q; // Shadow of the test clock bit.
	logic rd_st_q; // Read data now shows the status byte.
	logic [1:0] clr_q, clr2_q; // Recent write-one clears.
	logic [7:0] gap_q; // Cycles since the clock pin moved.
	logic scl_q; // Clock enable last cycle.
	// Helper state is kept off the design's own registers.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fast_q <= 1'b0;
			rd_st_q <= 1'b0;
			clr_q <= 2'h0;
			clr2_q <= 2'h0;
			gap_q <= 8'h00;
			scl_q <= 1'b0;
		end else begin
			if (cfg_wr && cfg_addr == 8'hb3) fast_q <= cfg_wdata[2];
			rd_st_q <= cfg_addr == 8'hb3;
			clr_q <= (cfg_wr && cfg_addr == 8'hb3) ? cfg_wdata[1:0] : 2'h0;
			clr2_q <= clr_q;
			scl_q <= scl_oe;
			gap_q <= (scl_q != scl_oe) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	rsvd_zero_a: assert property (rd_st_q |-> !cfg_rdata[6])
		else $error("reserved bit read as one");
	busy_present_a: assert property (rd_st_q && cfg_rdata[5] |-> !pins_free)
		else $error("busy with interface absent");
	load_present_a: assert property (rd_st_q && cfg_rdata[4] |-> !pins_free)
		else $error("loading with interface absent");
	detect_absent_a: assert property (rd_st_q && pins_free && $past(pins_free) |-> !cfg_rdata[3])
		else $error("detect set with pins free");
	pins_idle_a: assert property (pins_free |-> !scl_oe && !sda_oe)
		else $error("freed pins driven");
	reqerr_sticky_a: assert property (rd_st_q && $past(rd_st_q) && $past(cfg_rdata[1]) && !clr_q[1]
		&& !clr2_q[1] |-> cfg_rdata[1])
		else $error("request error lost");
	loaderr_sticky_a: assert property (rd_st_q && $past(rd_st_q) && $past(cfg_rdata[0]) && !clr_q[0]
		&& !clr2_q[0] |-> cfg_rdata[0])
		else $error("load error lost");
	normal_gap_a: assert property ($changed(scl_oe) && !fast_q |-> gap_q >= 8'h7c)
		else $error("serial clock too fast");
	fast_gap_a: assert property ($changed(scl_oe) && fast_q |-> gap_q >= 8'h1e)
		else $error("test clock too fast");
endmodule
bind sbhsc_top sbhsc_checker u_chk (.clk(clk), .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_oe(scl_oe), .sda_oe(sda_oe), .pins_free(pins_free));

// file: testbench/sbhsc_slave.sv
// Behavioural serial memory slave at the far side.
`timescale 1ns/1ns
module sbhsc_slave #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic nak,
	output logic sda_oe
);
	logic [7:0] mem [256]; // Byte store, first byte is the format tag.
	logic [7:0] sh, ptr, tx; // Shifter, pointer, byte being sent.
	logic act, first, rd, idx; // Frame state.
	int cnt; // Bit slot in the byte.
	initial begin
		sda_oe = 1'b0;
		act = 1'b0;
		ptr = 8'h00;
		for (int i = 0; i < 256; i++) mem[i] = (i == 0) ? 8'ha5 : 8'(i) ^ 8'h3c;
	end
	// Start or repeated start opens an address byte.
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		first = 1'b1;
		cnt = 0;
	end
	// Stop closes the frame.
	always @(posedge sda) if (scl) act = 1'b0;
	// Bits are taken on the rising clock; a host refusal ends a read.
	always @(posedge scl) if (act) begin
		if (cnt < 8) begin
			sh = {sh[6:0], sda};
			cnt++;
		end else begin
			cnt = 0;
			if (rd && sda) act = 1'b0;
		end
	end
	// Line changes only while the clock is low; the first written byte sets the pointer.
	always @(negedge scl) if (act) begin
		if (cnt == 8) begin
			if (first) begin
				rd = sh[0];
				idx = 1'b1;
				act = (sh[7:1] == ADDR) && !nak;
				tx = mem[ptr];
			end else if (!rd) begin
				if (idx) ptr = sh;
				else mem[ptr] = sh;
				idx = 1'b0;
			end else begin
				ptr++;
				tx = mem[ptr];
			end
			sda_oe = act && (first || !rd);
			first = 1'b0;
		end else sda_oe = rd && !first && !tx[7 - cnt];
	end
endmodule

// file: testbench/sbhsc_top_bench.sv
// Self-checking bench of the serial host.
`timescale 1ns/1ns
module sbhsc_top_bench;
	logic clk, rst_b, cfg_wr, latch_pin, nak, scl_oe, sda_oe, slv_oe, pins_free;
	logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v, d, ix;
	logic [7:0] em [256]; // Expected slave memory.
	int mismatches, n_checks, cyc;
	wire logic scl_w = !scl_oe; // Pulled-up clock wire.
	wire logic sda_w = !(sda_oe || slv_oe); // Pulled-up data wire.
	sbhsc_top #(.LOAD_BYTES(1)) u_dut (.clk(clk), .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_in(scl_w), .sda_in(sda_w), .scl_out(),
		.scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .latch_pin(latch_pin), .pins_free(pins_free),
		.subsys_byte(), .subsys_idx(), .subsys_valid());
	sbhsc_slave u_slv (.scl(scl_w), .sda(sda_w), .nak(nak), .sda_oe(slv_oe));
	function automatic logic [7:0] mval(input int i);
		return (i == 0) ? 8'ha5 : 8'(i) ^ 8'h3c;
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(negedge clk);
		cfg_addr = a;
		cfg_wdata = w;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		cfg_addr = a;
		@(negedge clk);
		v = cfg_rdata;
	endtask
	task automatic wait_clr(input int b);
		for (int i = 0; i < 15000; i++) begin
			rd(8'hb3);
			if (!v[b]) break;
		end
	endtask
	task automatic rst(input logic l, input logic n);
		latch_pin = l;
		nak = n;
		u_slv.ptr = 8'h00;
		rst_b = 1'b0;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cut a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 99000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		cyc = 0;
		mismatches = 0;
		n_checks = 0;
		{cfg_addr, cfg_wdata, cfg_wr} = 17'h00000;
		rst_b = 1'b0;
		latch_pin = 1'b0;
		nak = 1'b0;
		v = $urandom(32'h372580af);
		for (int i = 0; i < 256; i++) em[i] = mval(i);
		rst(1'b0, 1'b1);
		rd(8'hb3);
		chk("load busy", v & 8'h10, 8'h10);
		wait_clr(4);
		rd(8'hb3);
		chk("nak load", v, 8'h09);
		wr(8'hb3, 8'h00);
		rd(8'hb3);
		chk("zero write", v, 8'h09);
		wr(8'hb3, 8'h01);
		rd(8'hb3);
		chk("load clear", v, 8'h08);
		u_slv.mem[0] = 8'h00;
		rst(1'b0, 1'b0);
		wait_clr(4);
		rd(8'hb3);
		chk("bad format", v, 8'h09);
		u_slv.mem[0] = 8'ha5;
		rst(1'b1, 1'b0);
		wr(8'hb2, 8'ha1);
		rd(8'hb3);
		chk("absent", v, 8'h00);
		chk("pins free", {7'h00, pins_free}, 8'h01);
		rst(1'b0, 1'b0);
		wait_clr(4);
		rd(8'hb3);
		chk("loaded", v, 8'h08);
		wr(8'hb3, 8'hc4);
		rd(8'hb3);
		chk("ctrl", v, 8'h8c);
		wr(8'hb3, 8'h04);
		for (int i = 0; i < 4; i++) begin
			ix = (i == 0) ? 8'hff : 8'($urandom);
			d = (i == 0) ? 8'h00 : 8'($urandom);
			wr(8'hb0, d);
			wr(8'hb1, ix);
			wr(8'hb2, 8'ha0);
			rd(8'hb3);
			chk("busy", v, 8'h2c);
			wr(8'hb0, ~d);
			wait_clr(5);
			rd(8'hb3);
			chk("done", v, 8'h0c);
			rd(8'hb0);
			chk("kept data", v, d);
			em[ix] = d;
			wr(8'hb1, ix);
			wr(8'hb2, 8'ha1);
			wait_clr(5);
			rd(8'hb0);
			chk("read data", v, em[ix]);
		end
		wr(8'hb3, 8'h84);
		d = 8'($urandom);
		wr(8'hb0, d);
		wr(8'hb2, 8'ha0);
		wait_clr(5);
		wr(8'hb2, 8'ha1);
		wait_clr(5);
		rd(8'hb0);
		chk("short read", v, em[d]);
		wr(8'hb3, 8'h04);
		wr(8'hb2, 8'h42);
		wait_clr(5);
		rd(8'hb3);
		chk("req error", v, 8'h0e);
		wr(8'hb3, 8'h04);
		rd(8'hb3);
		chk("err kept", v, 8'h0e);
		wr(8'hb3, 8'h06);
		rd(8'hb3);
		chk("err clear", v, 8'h0c);
		final_report();
	end
endmodule
